// ===== core/timebase_defines.vh
// register map, field positions, reset values and tap indices of the periodic timebase
`ifndef TIMEBASE_DEFINES_VH
`define TIMEBASE_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TB_ADR_CONTROL   4'h0
`define TB_ADR_STATUS    4'h4
`define TB_ADR_MASK      4'h8
`define TB_ADR_COUNT     4'hc

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TB_BIT_FLAG      7
`define TB_RATE_HI       6
`define TB_RATE_LO       4
`define TB_BIT_ACK       3
`define TB_BIT_IRQ_EN    2
`define TB_BIT_ON        1

// status and mask registers share one layout
`define TB_BIT_ROLLOVER  0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TB_RST_RATE      3'h0
`define TB_RST_COUNT     15'h0000

// ----------------------------------------------------------------
// divider chain and tap stage per rate code
// ----------------------------------------------------------------
`define TB_STAGES        15
`define TB_TAP_32768     4'he
`define TB_TAP_8192      4'hc
`define TB_TAP_2048      4'ha
`define TB_TAP_128       4'h6
`define TB_TAP_64        4'h5
`define TB_TAP_32        4'h4
`define TB_TAP_16        4'h3
`define TB_TAP_8         4'h2

`endif

// ===== core/level_sync.v
// three-stage synchroniser with agreement filter and rising-edge pulse
module level_sync (
  input  wire clk_i,   // bus clock
  input  wire rst_i,   // synchronous reset, active high
  input  wire async_i, // level from another domain
  output reg  level_o, // filtered level
  output reg  rise_o   // one-cycle pulse on filtered rise
);

  reg meta;
  reg stage2;
  reg stage3;

  // ----------------------------------------------------------------
  // sampling chain
  // ----------------------------------------------------------------
  // the first flop only feeds the second; the filter looks at 2 and 3
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta    <= 1'b0;
      stage2  <= 1'b0;
      stage3  <= 1'b0;
      level_o <= 1'b0;
      rise_o  <= 1'b0;
    end else begin
      meta   <= async_i;
      stage2 <= meta;
      stage3 <= stage2;
      rise_o <= 1'b0;
      // a change counts only once stages two and three agree
      if (stage2 == stage3) begin
        level_o <= stage2;
        rise_o  <= stage2 & ~level_o;
      end
    end
  end

endmodule // level_sync

// ===== core/periodic_timebase_interrupt.v
// periodic timebase interrupt generator with classic wishbone register access
//
// The Wishbone register port and the address map were decided locally.
`include "timebase_defines.vh"

module periodic_timebase_interrupt #(
  parameter ADR_W = 4                  // byte address width seen by the slave
) (
  input  wire        clk_i,            // bus clock, 250 MHz
  input  wire        rst_i,            // synchronous reset, active high
  input  wire        cyc_i,            // wishbone cycle
  input  wire        stb_i,            // wishbone strobe
  input  wire        we_i,             // wishbone write enable
  input  wire [3:0]  sel_i,            // wishbone byte selects
  input  wire [ADR_W-1:0] adr_i,       // wishbone byte address
  input  wire [31:0] dat_i,            // wishbone write data
  output reg  [31:0] dat_o,            // wishbone read data
  output reg         ack_o,            // wishbone acknowledge
  output reg         err_o,            // wishbone error, unmapped or blocked
  input  wire        crystal_clock_i,  // 32.768 kHz crystal, sampled
  input  wire        wait_mode_i,      // processor in wait mode
  input  wire        stop_mode_i,      // processor in stop mode
  input  wire        osc_run_in_stop_i,// oscillator allowed to run in stop
  output wire        irq_o             // level interrupt request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [`TB_STAGES-1:0] chain;         // divider chain
  reg  [2:0]            rate_select;
  reg                   timebase_on;
  reg                   rollover_irq_enable;
  reg                   rollover_flag;

  wire                  xtal_level;
  wire                  xtal_rise;
  reg  [`TB_STAGES-1:0] next_chain;
  reg                   rollover;
  reg                   chain_run;

  // ----------------------------------------------------------------
  // tap decode
  // ----------------------------------------------------------------
  // stage index whose rising edge marks a rollover for a rate code
  function [3:0] tap_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    tap_of = `TB_TAP_32768;
        3'h1:    tap_of = `TB_TAP_8192;
        3'h2:    tap_of = `TB_TAP_2048;
        3'h3:    tap_of = `TB_TAP_128;
        3'h4:    tap_of = `TB_TAP_64;
        3'h5:    tap_of = `TB_TAP_32;
        3'h6:    tap_of = `TB_TAP_16;
        3'h7:    tap_of = `TB_TAP_8;
        default: tap_of = `TB_TAP_32768;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // crystal clock crossing
  // ----------------------------------------------------------------
  // the crystal is far slower than the bus clock, so it is sampled as
  // a level and its filtered rising edge advances the chain
  level_sync u_xtal_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (crystal_clock_i),
    .level_o (xtal_level),
    .rise_o  (xtal_rise)
  );

  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  // the chain is gated in stop mode unless the oscillator may run there
  always @* begin
    chain_run  = xtal_rise & (~stop_mode_i | osc_run_in_stop_i);
    next_chain = chain;
    rollover   = 1'b0;
    if (!timebase_on) begin
      next_chain = `TB_RST_COUNT;
    end else if (chain_run) begin
      next_chain = chain + 15'h0001;
      // a rising tap bit lands first at half the divider, then every
      // full divider, which gives the short first period
      rollover = next_chain[tap_of(rate_select)] &
                 ~chain[tap_of(rate_select)];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      chain <= `TB_RST_COUNT;
    end else begin
      chain <= next_chain;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       req        = cyc_i & stb_i;
  wire       low_power  = wait_mode_i | stop_mode_i;
  wire       hit_ctrl   = (adr_i == `TB_ADR_CONTROL);
  wire       hit_status = (adr_i == `TB_ADR_STATUS);
  wire       hit_mask   = (adr_i == `TB_ADR_MASK);
  wire       hit_count  = (adr_i == `TB_ADR_COUNT);
  wire       mapped     = hit_ctrl | hit_status | hit_mask | hit_count;
  // control access is refused while the processor sleeps
  wire       blocked    = hit_ctrl & low_power;
  wire       good       = mapped & ~blocked;
  // writes commit at the edge where the master samples ack
  wire       wr_commit  = req & we_i & ack_o & sel_i[0];
  wire [7:0] wbyte      = dat_i[7:0];

  wire       wr_ctrl    = wr_commit & hit_ctrl & ~low_power;
  wire       wr_status  = wr_commit & hit_status;
  wire       wr_mask    = wr_commit & hit_mask;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  // rate changes while running are accepted; software must avoid them
  always @(posedge clk_i) begin
    if (rst_i) begin
      timebase_on         <= 1'b0;
      rollover_irq_enable <= 1'b0;
      rate_select         <= `TB_RST_RATE;
    end else begin
      if (wr_ctrl) begin
        timebase_on         <= wbyte[`TB_BIT_ON];
        rollover_irq_enable <= wbyte[`TB_BIT_IRQ_EN];
        rate_select         <= wbyte[`TB_RATE_HI:`TB_RATE_LO];
      end else if (wr_mask) begin
        rollover_irq_enable <= wbyte[`TB_BIT_ROLLOVER];
      end
    end
  end

  // ----------------------------------------------------------------
  // rollover flag
  // ----------------------------------------------------------------
  // cleared by the acknowledge bit or a one to the status bit; a
  // rollover in the clearing cycle wins so no event is lost
  wire ack_clear = (wr_ctrl & wbyte[`TB_BIT_ACK]) |
                   (wr_status & wbyte[`TB_BIT_ROLLOVER]);

  always @(posedge clk_i) begin
    if (rst_i) begin
      rollover_flag <= 1'b0;
    end else if (rollover) begin
      rollover_flag <= 1'b1;
    end else if (ack_clear) begin
      rollover_flag <= 1'b0;
    end
  end

  assign irq_o = rollover_flag & rollover_irq_enable;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata[`TB_BIT_FLAG]              = rollover_flag;
      rdata[`TB_RATE_HI:`TB_RATE_LO]   = rate_select;
      rdata[`TB_BIT_ACK]               = 1'b0;
      rdata[`TB_BIT_IRQ_EN]            = rollover_irq_enable;
      rdata[`TB_BIT_ON]                = timebase_on;
    end else if (hit_status) begin
      rdata[`TB_BIT_ROLLOVER]          = rollover_flag;
    end else if (hit_mask) begin
      rdata[`TB_BIT_ROLLOVER]          = rollover_irq_enable;
    end else if (hit_count) begin
      rdata[`TB_STAGES-1:0]            = chain;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // one wait state: answer one cycle after the request, drop after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & good & ~ack_o & ~err_o;
      err_o <= req & ~good & ~ack_o & ~err_o;
      if (req & good & ~ack_o & ~err_o & ~we_i) begin
        dat_o <= rdata;
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule // periodic_timebase_interrupt

// ===== tb/timebase_properties.sv
// concurrent checks on the timebase register port
module timebase_properties #(
  parameter ADR_W = 4
) (
  input logic             clk_i,
  input logic             rst_i,
  input logic             cyc_i,
  input logic             stb_i,
  input logic             we_i,
  input logic [3:0]       sel_i,
  input logic [ADR_W-1:0] adr_i,
  input logic [31:0]      dat_i,
  input logic [31:0]      dat_o,
  input logic             ack_o,
  input logic             err_o,
  input logic             crystal_clock_i,
  input logic             wait_mode_i,
  input logic             stop_mode_i,
  input logic             osc_run_in_stop_i,
  input logic             irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // request shapes
  // ----------------------------------------------------------------
  sequence req_s;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence ctl_s;
    req_s ##0 (adr_i == 0);
  endsequence
  answer_next_a: assert property (req_s |=> ack_o || err_o)
    else $error("no answer one cycle after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  err_pulse_a: assert property (err_o |=> !err_o)
    else $error("err longer than one cycle");
  answer_cause_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i) && !(ack_o && err_o))
    else $error("answer without request");
  data_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  ctl_blocked_a: assert property (ctl_s ##0 (wait_mode_i || stop_mode_i) |=> err_o)
    else $error("control reachable in low power");
  ack_bit_a: assert property (ctl_s ##0 !we_i |=> !ack_o || dat_o[31:8] == 0 && !dat_o[3] && !dat_o[0])
    else $error("write only bit read back");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(ack_o && we_i))
    else $error("irq dropped without a write");
endmodule // timebase_properties

bind periodic_timebase_interrupt timebase_properties #(.ADR_W(ADR_W)) i_props (.*);

// ===== tb/test_periodic_timebase_interrupt.sv
// self-checking bench for the periodic timebase interrupt block
`include "timebase_defines.vh"
module test_periodic_timebase_interrupt;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  sel_i = 4'hf;
  logic [3:0]  adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic        irq_o;
  logic        crystal_clock_i = 1'b0;
  logic        wait_mode_i = 1'b0;
  logic        stop_mode_i = 1'b0;
  logic        osc_run_in_stop_i = 1'b0;
  logic [1:0]  ph = 2'h0;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          xedge = 0;
  int          divs[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

  periodic_timebase_interrupt #(.ADR_W(4)) i_dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .cyc_i             (cyc_i),
    .stb_i             (stb_i),
    .we_i              (we_i),
    .sel_i             (sel_i),
    .adr_i             (adr_i),
    .dat_i             (dat_i),
    .dat_o             (dat_o),
    .ack_o             (ack_o),
    .err_o             (err_o),
    .crystal_clock_i   (crystal_clock_i),
    .wait_mode_i       (wait_mode_i),
    .stop_mode_i       (stop_mode_i),
    .osc_run_in_stop_i (osc_run_in_stop_i),
    .irq_o             (irq_o)
  );

  initial forever #2 clk_i = ~clk_i;
  // crystal stand-in: eight bus cycles a period, far slower than the sampler needs
  always @(posedge clk_i) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3) begin
      crystal_clock_i <= ~crystal_clock_i;
      xedge <= xedge + (crystal_clock_i ? 0 : 1);
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; rd holds read data, or err in bit 0 when refused
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
    rd = (err_o === 1'b1) ? 32'h1 : dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k == 20) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic wirq(input logic lvl);
    int k;
    for (k = 0; k < 4000 && irq_o !== lvl; k++) @(posedge clk_i);
    if (k == 4000) begin
      error_cnt++;
      end_sim();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    wb(1'b0, `TB_ADR_CONTROL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `TB_ADR_COUNT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_fields();
    wb(1'b1, `TB_ADR_CONTROL, 32'h7c);
    wb(1'b0, `TB_ADR_CONTROL, 32'h0);
    chk(rd, 32'h74);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, `TB_ADR_CONTROL, c << 4);
      wb(1'b0, `TB_ADR_CONTROL, 32'h0);
      chk(rd, c << 4);
    end
    $display("t_fields done");
  endtask
  // half period to the first flag, then whole periods; both clear paths
  task automatic t_rate(input logic [2:0] c);
    int n0;
    wb(1'b1, `TB_ADR_CONTROL, 32'h0);
    wb(1'b1, `TB_ADR_STATUS, 32'h1);
    wb(1'b1, `TB_ADR_CONTROL, {c, 4'h6});
    n0 = xedge;
    wirq(1'b1);
    // a pin edge just before the enable lands may reach the chain after it,
    // so the chain can be one edge ahead of the count taken here
    chk(xedge - n0 >= divs[c] / 2 - 1 && xedge - n0 <= divs[c] / 2, 1);
    n0 = xedge;
    wb(1'b1, `TB_ADR_CONTROL, {c, 4'h6});
    @(posedge clk_i);
    chk(irq_o, 1);
    wb(1'b1, `TB_ADR_CONTROL, {c, 4'he});
    @(posedge clk_i);
    chk(irq_o, 0);
    wirq(1'b1);
    chk(xedge - n0, divs[c]);
    $display("t_rate %0d done", c);
  endtask
  task automatic t_modes();
    int n;
    wb(1'b1, `TB_ADR_CONTROL, 32'h76);
    wb(1'b1, `TB_ADR_STATUS, 32'h1);
    wait_mode_i <= 1'b1;
    wb(1'b1, `TB_ADR_CONTROL, 32'h0);
    chk(rd, 32'h1);
    wirq(1'b1);
    wb(1'b0, `TB_ADR_MASK, 32'h0);
    chk(rd, 32'h1);
    wait_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    wb(1'b0, `TB_ADR_COUNT, 32'h0);
    n = rd;
    repeat (40) @(posedge clk_i);
    wb(1'b0, `TB_ADR_COUNT, 32'h0);
    chk(rd, n);
    wb(1'b0, `TB_ADR_CONTROL, 32'h0);
    chk(rd, 32'h1);
    osc_run_in_stop_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    wb(1'b0, `TB_ADR_COUNT, 32'h0);
    chk(rd !== n, 1);
    stop_mode_i <= 1'b0;
    wb(1'b1, `TB_ADR_MASK, 32'h0);
    wb(1'b1, `TB_ADR_STATUS, 32'h1);
    repeat (80) @(posedge clk_i);
    chk(irq_o, 0);
    wb(1'b0, `TB_ADR_STATUS, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, `TB_ADR_CONTROL, 32'h0);
    repeat (16) @(posedge clk_i);
    wb(1'b0, `TB_ADR_COUNT, 32'h0);
    chk(rd, 32'h0);
    $display("t_modes done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    for (int c = 3; c < 8; c++) t_rate(c);
    t_modes();
    end_sim();
  end
endmodule // test_periodic_timebase_interrupt
